// ### core/osc_clk_pkg.sv
/*
 * Shared constants and types for the oscillator and system clock select block.
 * Assumes a single 250 MHz design clock; every oscillator is modelled as an
 * enable-driven level derived from that clock.
 */
package osc_clk_pkg;

    // ------------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int HF_HALF_PS    = 31250;     // 16 MHz
    localparam int LF_HALF_PS    = 16129032;  // 31 kHz
    localparam int FRC_HALF_PS   = 833333;    // 600 kHz nominal
    localparam int HF_START_NS   = 2000;
    localparam int HF_STABLE_NS  = 4000;
    localparam int LF_START_NS   = 4000;
    localparam int FRC_START_NS  = 1000;

    localparam int HF_HALF_CYC   = HF_HALF_PS / CLK_PERIOD_PS;
    localparam int LF_HALF_CYC   = LF_HALF_PS / CLK_PERIOD_PS;
    localparam int FRC_HALF_CYC  = FRC_HALF_PS / CLK_PERIOD_PS;
    localparam int HF_START_CYC  = (HF_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HF_STABLE_CYC = (HF_STABLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LF_START_CYC  = (LF_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int FRC_START_CYC = (FRC_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ------------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int DIV_W  = 9;

    localparam logic [ADDR_W-1:0] ADDR_OSC_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_OSC_STATUS  = 4'h1;

    localparam int INT_FREQ_SELECT_LSB        = 3;
    localparam int INT_FREQ_SELECT_W          = 4;
    localparam int SCS_LSB         = 0;
    localparam int SCS_W           = 2;
    localparam int HF_READY_BIT    = 4;
    localparam int LF_READY_BIT    = 1;
    localparam int HF_STABLE_BIT   = 0;
    localparam int SWITCH_BUSY_BIT = 7;

    localparam logic [INT_FREQ_SELECT_W-1:0] INT_FREQ_SELECT_RESET = 4'h7;
    localparam logic [SCS_W-1:0]  SCS_RESET  = 2'h0;

    // ------------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_INTERNAL_OSC          = 2'h0,
        MODE_EXT_CLK_LOW_POWER     = 2'h1,
        MODE_EXT_CLK_MEDIUM_POWER  = 2'h2,
        MODE_EXT_CLK_HIGH_POWER    = 2'h3
    } clk_mode_t;

    typedef enum logic [2:0] {
        SRC_EXT = 3'h1,
        SRC_HF  = 3'h2,
        SRC_LF  = 3'h4
    } clk_src_t;

    typedef enum logic [3:0] {
        SW_RUN   = 4'h1,
        SW_START = 4'h2,
        SW_FALL  = 4'h4,
        SW_HOLD  = 4'h8
    } sw_state_t;

    // upper three select bits clear pick the low-frequency oscillator
    function automatic logic freq_is_lf(input logic [INT_FREQ_SELECT_W-1:0] sel);
        return sel[INT_FREQ_SELECT_W-1:1] == 3'h0;
    endfunction

    // divide-by-two stages behind the 16 MHz oscillator
    function automatic logic [3:0] postscale_exp(input logic [INT_FREQ_SELECT_W-1:0] sel);
        unique case (sel)
            4'hF:    return 4'h0;
            4'hE:    return 4'h1;
            4'hD:    return 4'h2;
            4'hC:    return 4'h3;
            4'hB:    return 4'h4;
            4'hA:    return 4'h5;
            4'h9:    return 4'h6;
            4'h8:    return 4'h7;
            4'h7:    return 4'h5;
            4'h6:    return 4'h6;
            4'h5:    return 4'h7;
            4'h4:    return 4'h8;
            default: return 4'h9;
        endcase
    endfunction

endpackage

// ### core/osc_link_if.sv
/*
 * Bundle between an oscillator source and its consumer.
 * Assumes every signal is synchronous to the design clock.
 */
`timescale 1ns/1ps
interface osc_link_if;
    logic en;
    logic lvl;
    logic rise;
    logic ready;
    logic stable;

    modport src  (input en, output lvl, output rise, output ready, output stable);
    modport sink (output en, input lvl, input rise, input ready, input stable);
endinterface

// ### core/osc_source.sv
/*
 * One oscillator: start-up delay, ready and stable flags, free-running level.
 * Assumes the enable comes from the clock select logic on the same clock.
 */
`timescale 1ns/1ps
module osc_source #(
    parameter int HALF_CYC   = 7,
    parameter int START_CYC  = 500,
    parameter int STABLE_CYC = 1000
) (
    input  wire logic   mclk,
    input  wire logic   arst_n,
    osc_link_if.src     osc
);
    localparam int CW = $clog2(HALF_CYC + 1);
    localparam int SW = $clog2(START_CYC + STABLE_CYC + 1);

    typedef struct packed {
        logic [CW-1:0] tick;
        logic [SW-1:0] waitCnt;
        logic          lvl;
        logic          rise;
        logic          ready;
        logic          stable;
    } src_state_t;

    src_state_t q;
    src_state_t d;

    always_comb begin
        d = q;
        d.rise = 1'b0;
        if (!osc.en) begin
            d = '0;
        end else if (!q.ready) begin
            if (q.waitCnt == SW'(START_CYC - 1)) begin
                d.ready = 1'b1;
                d.waitCnt = '0;
            end else begin
                d.waitCnt = q.waitCnt + 1'b1;
            end
        end else begin
            if (!q.stable) begin
                if (q.waitCnt == SW'(STABLE_CYC - 1)) begin
                    d.stable = 1'b1;
                end else begin
                    d.waitCnt = q.waitCnt + 1'b1;
                end
            end
            if (q.tick == CW'(HALF_CYC - 1)) begin
                d.tick = '0;
                d.lvl = ~q.lvl;
                d.rise = ~q.lvl;
            end else begin
                d.tick = q.tick + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign osc.lvl    = q.lvl;
    assign osc.rise   = q.rise;
    assign osc.ready  = q.ready;
    assign osc.stable = q.stable;
endmodule

// ### core/hf_postscaler.sv
/*
 * Postscaler behind the high-frequency oscillator.
 * Assumes the frequency select comes straight from the control register and can change on any write.
 */
`timescale 1ns/1ps
module hf_postscaler #(
    parameter int DIV_W = osc_clk_pkg::DIV_W
) (
    input  wire logic                           mclk,
    input  wire logic                           arst_n,
    input  wire logic [osc_clk_pkg::INT_FREQ_SELECT_W-1:0] freqSel,
    osc_link_if.sink                            hf,
    osc_link_if.src                             div
);
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             lvl;
        logic             rise;
    } ps_state_t;

    ps_state_t  q;
    ps_state_t  d;
    logic [3:0] stages;
    logic       nextLvl;

    assign stages = osc_clk_pkg::postscale_exp(freqSel);

    always_comb begin
        d = q;
        nextLvl = 1'b0;
        d.rise = 1'b0;
        if (!hf.ready) begin
            d = '0;
        end else begin
            if (hf.rise) begin
                d.cnt = q.cnt + 1'b1;
            end
            nextLvl = (stages == 4'h0) ? hf.lvl : d.cnt[stages - 4'h1];
            d.lvl = nextLvl;
            d.rise = nextLvl & ~q.lvl;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // the oscillator runs whenever its divided output is wanted
    assign hf.en      = div.en;
    assign div.lvl    = q.lvl;
    assign div.rise   = q.rise;
    assign div.ready  = hf.ready;
    assign div.stable = hf.stable;
endmodule

// ### core/oscillator_clock_select.sv
/*
 * Oscillator and system clock source selection with control/status registers.
 * Assumes config-word fields are static straps and all pins are synchronous
 * to mclk; register port reads answer one cycle after the strobe.
 */
`timescale 1ns/1ps
module oscillator_clock_select (
    input  wire logic                           mclk,
    input  wire logic                           arst_n,
    input  wire logic [osc_clk_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [osc_clk_pkg::DATA_W-1:0] regWrData,
    input  wire logic                           regWr,
    input  wire logic                           regRd,
    output logic      [osc_clk_pkg::DATA_W-1:0] regRdData,
    input  wire logic [1:0]                     cfgOscMode,
    input  wire logic                           cfgClkOutEn,
    input  wire logic                           extClkIn,
    input  wire logic                           gpioClkOutO,
    input  wire logic                           gpioClkOutOe,
    input  wire logic                           lfPeriphReq,
    input  wire logic                           frcReq,
    input  wire logic                           sleepMode,
    output logic                                sysClk,
    output logic                                fastStartActive,
    output logic                                clkOutPinO,
    output logic                                clkOutPinOe,
    output logic                                clkInGpioMode,
    output logic                                lfTimeBase,
    output logic                                frcClk
);
    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [osc_clk_pkg::INT_FREQ_SELECT_W-1:0] freqSel;
        logic [osc_clk_pkg::SCS_W-1:0]  srcSel;
        osc_clk_pkg::clk_mode_t         cfgMode;
        logic                           cfgLoaded;
        osc_clk_pkg::sw_state_t         sw;
        osc_clk_pkg::clk_src_t          actSrc;
        osc_clk_pkg::clk_src_t          newSrc;
        logic [osc_clk_pkg::INT_FREQ_SELECT_W-1:0] actFreq;
        logic                           sysClk;
        logic                           fastStart;
        logic                           clkOutO;
        logic                           clkOutOe;
        logic                           clkInGpio;
        logic                           lfTick;
        logic                           frcClk;
        logic [osc_clk_pkg::DATA_W-1:0] rdData;
    } top_state_t;

    top_state_t             q;
    top_state_t             d;
    osc_clk_pkg::clk_src_t  tgtSrc;
    osc_clk_pkg::clk_src_t  loadSrc;
    logic                   hfWanted;
    logic                   lfWanted;

    osc_link_if hfRaw ();
    osc_link_if hfDiv ();
    osc_link_if lfIf ();
    osc_link_if frcIf ();

    // ------------------------------------------------------------------------
    // oscillators
    // ------------------------------------------------------------------------
    osc_source #(
        .HALF_CYC   (osc_clk_pkg::HF_HALF_CYC),
        .START_CYC  (osc_clk_pkg::HF_START_CYC),
        .STABLE_CYC (osc_clk_pkg::HF_STABLE_CYC)
    ) hfOsc (
        .mclk   (mclk),
        .arst_n (arst_n),
        .osc    (hfRaw)
    );

    hf_postscaler hfPs (
        .mclk    (mclk),
        .arst_n  (arst_n),
        .freqSel (q.freqSel),
        .hf      (hfRaw),
        .div     (hfDiv)
    );

    osc_source #(
        .HALF_CYC   (osc_clk_pkg::LF_HALF_CYC),
        .START_CYC  (osc_clk_pkg::LF_START_CYC),
        .STABLE_CYC (1)
    ) lfOsc (
        .mclk   (mclk),
        .arst_n (arst_n),
        .osc    (lfIf)
    );

    osc_source #(
        .HALF_CYC   (osc_clk_pkg::FRC_HALF_CYC),
        .START_CYC  (osc_clk_pkg::FRC_START_CYC),
        .STABLE_CYC (1)
    ) frcOsc (
        .mclk   (mclk),
        .arst_n (arst_n),
        .osc    (frcIf)
    );

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic osc_clk_pkg::clk_src_t pick_src(
        input osc_clk_pkg::clk_mode_t         mode,
        input logic [osc_clk_pkg::SCS_W-1:0]  sel,
        input logic [osc_clk_pkg::INT_FREQ_SELECT_W-1:0] freq
    );
        // no secondary oscillator here, so select 01 behaves like 00
        if (sel[osc_clk_pkg::SCS_W-1] || mode == osc_clk_pkg::MODE_INTERNAL_OSC) begin
            return osc_clk_pkg::freq_is_lf(freq) ? osc_clk_pkg::SRC_LF : osc_clk_pkg::SRC_HF;
        end
        return osc_clk_pkg::SRC_EXT;
    endfunction

    function automatic logic src_level(input osc_clk_pkg::clk_src_t src);
        unique case (src)
            osc_clk_pkg::SRC_EXT: return extClkIn;
            osc_clk_pkg::SRC_HF:  return hfDiv.lvl;
            default:              return lfIf.lvl;
        endcase
    endfunction

    function automatic logic src_ready(input osc_clk_pkg::clk_src_t src);
        unique case (src)
            osc_clk_pkg::SRC_EXT: return 1'b1;
            osc_clk_pkg::SRC_HF:  return hfDiv.ready;
            default:              return lfIf.ready;
        endcase
    endfunction

    assign tgtSrc  = pick_src(q.cfgMode, q.srcSel, q.freqSel);
    assign loadSrc = pick_src(osc_clk_pkg::clk_mode_t'(cfgOscMode), q.srcSel, q.freqSel);

    // old source stays up until the switch has handed over
    assign hfWanted = ~sleepMode
                    & ((~osc_clk_pkg::freq_is_lf(q.freqSel)
                        & (q.cfgMode == osc_clk_pkg::MODE_INTERNAL_OSC
                           | q.srcSel[osc_clk_pkg::SCS_W-1]))
                       | (q.actSrc == osc_clk_pkg::SRC_HF & q.sw != osc_clk_pkg::SW_RUN));
    assign lfWanted = (osc_clk_pkg::freq_is_lf(q.freqSel) & q.srcSel[osc_clk_pkg::SCS_W-1])
                    | lfPeriphReq
                    | (q.actSrc == osc_clk_pkg::SRC_LF & q.sw != osc_clk_pkg::SW_RUN);

    assign hfDiv.en = hfWanted;
    assign lfIf.en  = lfWanted;
    assign frcIf.en = frcReq;

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        d = q;
        d.lfTick = lfIf.rise;
        d.frcClk = frcIf.lvl;
        d.rdData = '0;
        d.fastStart = 1'b0;

        // straps are caught once, on the first edge after reset release
        if (!q.cfgLoaded) begin
            d.cfgLoaded = 1'b1;
            d.cfgMode = osc_clk_pkg::clk_mode_t'(cfgOscMode);
            d.actSrc = loadSrc;
            d.newSrc = loadSrc;
            d.actFreq = q.freqSel;
        end

        if (regWr && regAddr == osc_clk_pkg::ADDR_OSC_CONTROL) begin
            d.freqSel = regWrData[osc_clk_pkg::INT_FREQ_SELECT_LSB +: osc_clk_pkg::INT_FREQ_SELECT_W];
            d.srcSel = regWrData[osc_clk_pkg::SCS_LSB +: osc_clk_pkg::SCS_W];
        end

        if (regRd && regAddr == osc_clk_pkg::ADDR_OSC_CONTROL) begin
            d.rdData[osc_clk_pkg::INT_FREQ_SELECT_LSB +: osc_clk_pkg::INT_FREQ_SELECT_W] = q.freqSel;
            d.rdData[osc_clk_pkg::SCS_LSB +: osc_clk_pkg::SCS_W] = q.srcSel;
        end else if (regRd && regAddr == osc_clk_pkg::ADDR_OSC_STATUS) begin
            d.rdData[osc_clk_pkg::HF_READY_BIT] = hfDiv.ready;
            d.rdData[osc_clk_pkg::HF_STABLE_BIT] = hfDiv.stable;
            d.rdData[osc_clk_pkg::LF_READY_BIT] = lfIf.ready;
            d.rdData[osc_clk_pkg::SWITCH_BUSY_BIT] = q.sw != osc_clk_pkg::SW_RUN;
        end

        unique case (q.sw)
            osc_clk_pkg::SW_RUN: begin
                d.sysClk = src_level(q.actSrc) & ~sleepMode;
                if (q.cfgLoaded && (tgtSrc != q.actSrc || q.freqSel != q.actFreq)) begin
                    d.newSrc = tgtSrc;
                    d.actFreq = q.freqSel;
                    d.sw = osc_clk_pkg::SW_START;
                end
            end
            osc_clk_pkg::SW_START: begin
                // a ready source skips the delay, as within one oscillator
                d.sysClk = src_level(q.actSrc) & ~sleepMode;
                d.fastStart = (q.newSrc == osc_clk_pkg::SRC_HF) & ~hfDiv.ready;
                if (src_ready(q.newSrc)) begin
                    d.sw = osc_clk_pkg::SW_FALL;
                end
            end
            osc_clk_pkg::SW_FALL: begin
                d.sysClk = src_level(q.actSrc) & ~sleepMode;
                if (!src_level(q.actSrc)) begin
                    d.sysClk = 1'b0;
                    d.sw = osc_clk_pkg::SW_HOLD;
                end
            end
            osc_clk_pkg::SW_HOLD: begin
                d.sysClk = 1'b0;
                if (src_level(q.newSrc)) begin
                    d.actSrc = q.newSrc;
                    d.sysClk = ~sleepMode;
                    d.sw = osc_clk_pkg::SW_RUN;
                end
            end
            default: begin
                d.sw = osc_clk_pkg::SW_RUN;
            end
        endcase

        // external clock only counts when an external mode is active
        d.clkInGpio = q.cfgMode == osc_clk_pkg::MODE_INTERNAL_OSC;
        d.clkOutOe = cfgClkOutEn | gpioClkOutOe;
        d.clkOutO = cfgClkOutEn ? d.sysClk : gpioClkOutO;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '{freqSel: osc_clk_pkg::INT_FREQ_SELECT_RESET,
                   srcSel:  osc_clk_pkg::SCS_RESET,
                   cfgMode: osc_clk_pkg::MODE_INTERNAL_OSC,
                   sw:      osc_clk_pkg::SW_RUN,
                   actSrc:  osc_clk_pkg::SRC_HF,
                   newSrc:  osc_clk_pkg::SRC_HF,
                   actFreq: osc_clk_pkg::INT_FREQ_SELECT_RESET,
                   default: '0};
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign regRdData       = q.rdData;
    assign sysClk          = q.sysClk;
    assign fastStartActive = q.fastStart;
    assign clkOutPinO      = q.clkOutO;
    assign clkOutPinOe     = q.clkOutOe;
    assign clkInGpioMode   = q.clkInGpio;
    assign lfTimeBase      = q.lfTick;
    assign frcClk          = q.frcClk;
endmodule

// ### test/ext_clk_src.sv
/*
 * Model of the outside oscillator that feeds the clock input pin.
 * Assumes the bench clock paces it; it stands low while stopped.
 */
`timescale 1ns/1ps
module ext_clk_src #(
    parameter int HALF = 3
) (
    input  wire logic mclk,
    input  wire logic run,
    output logic      clk_output_pin = 1'b0
);
    int cnt = 0;

    // plain logic-level square wave, no slew or amplitude modelled
    always @(posedge mclk) begin
        if (!run) begin
            clk_output_pin <= 1'b0;
            cnt    <= 0;
        end else if (cnt == HALF - 1) begin
            clk_output_pin <= ~clk_output_pin;
            cnt    <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// ### test/osc_clk_chk.sv
/*
 * Port-level assertions for the oscillator clock select block.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
module osc_clk_chk (
    input wire logic       mclk,
    input wire logic       arst_n,
    input wire logic [3:0] regAddr,
    input wire logic       regRd,
    input wire logic [7:0] regRdData,
    input wire logic [1:0] cfgOscMode,
    input wire logic       cfgClkOutEn,
    input wire logic       gpioClkOutO,
    input wire logic       gpioClkOutOe,
    input wire logic       frcReq,
    input wire logic       sysClk,
    input wire logic       fastStartActive,
    input wire logic       clkOutPinO,
    input wire logic       clkOutPinOe,
    input wire logic       clkInGpioMode,
    input wire logic       lfTimeBase,
    input wire logic       frcClk
);
    logic [1:0] upCnt_q;
    logic [9:0] frcCnt_q;

    // straps settle only after the first edges out of reset
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            upCnt_q  <= 2'h0;
            frcCnt_q <= 10'h000;
        end else begin
            upCnt_q  <= (upCnt_q == 2'h3) ? upCnt_q : upCnt_q + 2'h1;
            frcCnt_q <= !frcReq ? 10'h000 : ((&frcCnt_q) ? frcCnt_q : frcCnt_q + 10'h001);
        end
    end

    // ------------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    rd_idle_a: assert property (!regRd |=> regRdData == 8'h00)
        else $error("read data not idle");
    rd_unmap_a: assert property (regRd && regAddr > 4'h1 |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    ctrl_pad_a: assert property (regRd && regAddr == 4'h0 |=> !regRdData[7] && !regRdData[2])
        else $error("control spare bits set");
    stat_pad_a: assert property (regRd && regAddr == 4'h1 |=> regRdData[6:5] == 2'h0
        && regRdData[3:2] == 2'h0) else $error("status spare bits set");
    pin_oe_a: assert property (upCnt_q == 2'h3 && $stable(cfgClkOutEn) && $stable(gpioClkOutOe)
        |-> clkOutPinOe == (cfgClkOutEn | gpioClkOutOe)) else $error("clock pin enable wrong");
    pin_gpio_a: assert property (upCnt_q == 2'h3 && !cfgClkOutEn && $stable(gpioClkOutO)
        |-> clkOutPinO == gpioClkOutO) else $error("clock pin not gpio");
    clk_out_a: assert property (upCnt_q == 2'h3 && cfgClkOutEn && $stable(cfgClkOutEn)
        |-> clkOutPinO == sysClk) else $error("clock pin not system clock");
    clk_in_pin_free_a: assert property (upCnt_q == 2'h3 && cfgOscMode == 2'h0 |-> clkInGpioMode)
        else $error("clock input pin not freed");
    frc_run_a: assert property (frcCnt_q > 10'h140 |-> ##[1:210] $changed(frcClk))
        else $error("rc clock stopped");
    lf_pulse_a: assert property (lfTimeBase |=> !lfTimeBase)
        else $error("time base pulse too long");
    fast_end_a: assert property ($rose(fastStartActive) |-> ##[1:600] !fastStartActive)
        else $error("fast start never ends");

    cover property ($fell(fastStartActive));
    cover property (lfTimeBase);
    cover property (regRd && regAddr == 4'h1 ##1 regRdData != 8'h00);
endmodule

// ### test/tb_top.sv
/*
 * Self-checking bench for the oscillator clock select block.
 * Assumes a read answers exactly one cycle after its strobe.
 */
`timescale 1ns/1ps
module tb_top;
    logic       mclk = 1'b0, arst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, extRun = 1'b0;
    logic       cfgClkOutEn = 1'b0, gpioClkOutO = 1'b0, gpioClkOutOe = 1'b0, fastSeen = 1'b0;
    logic       lfPeriphReq = 1'b0, frcReq = 1'b0, sleepMode = 1'b0, extClkIn;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00, regRdData, ctrlModel, rdv;
    logic [1:0] cfgOscMode = 2'h0;
    logic       sysClk, fastStartActive, clkOutPinO, clkOutPinOe, clkInGpioMode, lfTimeBase, frcClk;
    int         error_cnt = 0, total_checks = 0, cycles = 0, n;

    always #2 mclk = ~mclk;

    always @(posedge mclk) begin
        cycles++;
        if (fastStartActive === 1'b1) fastSeen = 1'b1;
        if (cycles == 80000) begin
            error_cnt++;
            results();
        end
    end

    ext_clk_src #(.HALF(3)) u_ext (.mclk, .run(extRun), .clk_output_pin(extClkIn));
    oscillator_clock_select u_dut (.mclk, .arst_n, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData, .cfgOscMode, .cfgClkOutEn, .extClkIn, .gpioClkOutO, .gpioClkOutOe,
        .lfPeriphReq, .frcReq, .sleepMode, .sysClk, .fastStartActive, .clkOutPinO,
        .clkOutPinOe, .clkInGpioMode, .lfTimeBase, .frcClk);

    // ------------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
        if (a == 4'h0) ctrlModel = d & 8'h7B;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 d = regRdData;
        @(posedge mclk);
    endtask

    // one spare edge first: busy lands on the edge after the write
    task automatic waitStat(input int b, input logic v, input int lim);
        @(posedge mclk);
        n = 0;
        rd(4'h1, rdv);
        while (rdv[b] !== v && n < lim) begin
            rd(4'h1, rdv);
            n++;
        end
    endtask

    task automatic doReset(input logic [1:0] m);
        arst_n      <= 1'b0;
        cfgOscMode  <= m;
        cfgClkOutEn <= m[0];
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        ctrlModel = 8'h38;
        repeat (2) @(posedge mclk);
    endtask

    task automatic countEdges(ref logic s, input int cyc, output int cnt);
        logic last;
        cnt = 0;
        last = s;
        repeat (cyc) begin
            @(posedge mclk);
            if (s !== last) cnt++;
            last = s;
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        n = $urandom(64494);
        for (int m = 0; m < 4; m++) begin
            gpioClkOutO  <= 1'($urandom);
            gpioClkOutOe <= 1'($urandom);
            extRun       <= 1'b1;
            doReset(2'(m));
            rd(4'h0, rdv);
            check("control reset", ctrlModel, rdv);
            check("clock input pin", 8'(m == 0), 8'(clkInGpioMode));
            check("clock pin enable", 8'(cfgClkOutEn | gpioClkOutOe), 8'(clkOutPinOe));
            countEdges(sysClk, 60, n);
            check("external clock followed", 8'(m != 0), 8'(n > 4));
            wr(4'h9, 8'($urandom));
            rd(4'h9, rdv);
            check("unmapped read", 8'h00, rdv);
            rd(4'h0, rdv);
            check("control kept", ctrlModel, rdv);
            $display("mode test %0d done", m);
        end
        wr(4'h0, {1'b0, 4'h8 | 4'($urandom), 1'b0, 2'h2});
        rd(4'h0, rdv);
        check("control readback", ctrlModel, rdv);
        waitStat(4, 1'b1, 400);
        check("hf ready", 8'h01, 8'(rdv[4]));
        waitStat(0, 1'b1, 1000);
        check("hf stable", 8'h01, 8'(rdv[0]));
        waitStat(7, 1'b0, 2000);
        check("hf status", 8'h11, rdv);
        check("fast start seen", 8'h01, 8'(fastSeen));
        fastSeen = 1'b0;
        wr(4'h0, {1'b0, 4'h8 | 4'($urandom), 1'b0, 2'h3});
        waitStat(7, 1'b0, 1000);
        check("hf to hf status", 8'h11, rdv);
        check("hf to hf start", 8'h00, 8'(fastSeen));
        $display("hf test done");
        wr(4'h0, 8'h02);
        waitStat(7, 1'b0, 6000);
        repeat (4) @(posedge mclk);
        rd(4'h1, rdv);
        check("lf status", 8'h02, rdv);
        $display("lf test done");
        frcReq      <= 1'b1;
        sleepMode   <= 1'b1;
        lfPeriphReq <= 1'b1;
        countEdges(frcClk, 1200, n);
        check("rc clock in sleep", 8'h01, 8'(n >= 4));
        countEdges(lfTimeBase, 9000, n);
        check("lf time base", 8'h01, 8'(n >= 2));
        $display("peripheral clock test done");
        results();
    end
endmodule

bind oscillator_clock_select osc_clk_chk u_chk (.mclk, .arst_n, .regAddr, .regRd, .regRdData,
    .cfgOscMode, .cfgClkOutEn, .gpioClkOutO, .gpioClkOutOe, .frcReq, .sysClk, .fastStartActive,
    .clkOutPinO, .clkOutPinOe, .clkInGpioMode, .lfTimeBase, .frcClk);
